// ===== hw/count_core_pkg.sv
// Package for the prescaled count core: register map, field positions, reset values.
// Assumes an 8-bit register port with byte-wide registers at small word indices.
package count_core_pkg;

    // ==================================================================
    // Widths
    localparam int unsigned ADDR_W    = 3;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned COUNT_W   = 16;
    localparam int unsigned PRESC_W   = 6;
    localparam int unsigned DIV_SEL_W = 3;

    // ==================================================================
    // Register indices
    localparam logic [ADDR_W-1:0] ADDR_STATUS_CONTROL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH     = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW      = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT_HIGH     = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT_LOW      = 3'h4;

    // ==================================================================
    // Status/control field positions
    localparam int unsigned BIT_WRAP_FLAG  = 7;
    localparam int unsigned BIT_WRAP_IE    = 6;
    localparam int unsigned BIT_HALT       = 5;
    localparam int unsigned BIT_CLEAR      = 4;
    localparam int unsigned DIV_SEL_LSB    = 0;

    // ==================================================================
    // Reset values and constants
    localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET = 3'h0;
    localparam logic [DIV_SEL_W-1:0] DIV_SEL_NONE  = 3'h7;
    localparam logic [COUNT_W-1:0]   COUNT_RESET   = 16'h0000;
    localparam logic [COUNT_W-1:0]   LIMIT_RESET   = 16'hFFFF;
    localparam logic [PRESC_W-1:0]   PRESC_RESET   = 6'h00;
    localparam logic [DATA_W-1:0]    BYTE_ZERO     = 8'h00;

endpackage

// ===== hw/count_prescaler.sv
// Prescaler: divider that counts while run and issues one counter tick per 2**sel bus clocks, none for sel 7.
// Assumes run and clear come from the core's registers on the same clock.
module count_prescaler #(
    parameter int unsigned PRESC_W = count_core_pkg::PRESC_W,
    parameter int unsigned SEL_W   = count_core_pkg::DIV_SEL_W
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // Control
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic [SEL_W-1:0] sel,
    // Counter tick
    output logic                  tick
);

    // ==================================================================
    // Divider chain
    logic [PRESC_W-1:0] div_reg;
    logic [PRESC_W-1:0] div_next;
    logic [PRESC_W-1:0] sel_mask;

    // Tick when the low sel bits are all ones; code 7 gives no tick
    always_comb begin
        sel_mask = PRESC_W'((PRESC_W'(1) << sel) - PRESC_W'(1));
        tick     = run && (sel != count_core_pkg::DIV_SEL_NONE)
                   && ((div_reg & sel_mask) == sel_mask);
    end

    // Next divider value
    always_comb begin
        div_next = div_reg;
        if (clear) begin
            div_next = count_core_pkg::PRESC_RESET;
        end else if (run) begin
            div_next = PRESC_W'(div_reg + PRESC_W'(1));
        end
    end

    // Divider register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= count_core_pkg::PRESC_RESET;
        end else if (ce) begin
            div_reg <= div_next;
        end
    end

endmodule // count_prescaler

// ===== hw/prescaled_count_core.sv
// Prescaled count core: 16-bit wrapping up-counter with status/control register,
// latched counter byte pair and limit registers on a plain strobe port.
// Assumes wait, stop, break and break_clear_allow come synchronous from system logic.
//
// Local design decisions: the plain strobed port and the register offsets.

module prescaled_count_core #(
    parameter int unsigned NUM_CHAN = 4,
    parameter int unsigned ADDR_W   = count_core_pkg::ADDR_W,
    parameter int unsigned DATA_W   = count_core_pkg::DATA_W,
    parameter int unsigned COUNT_W  = count_core_pkg::COUNT_W
) (
    // Clock, reset, clock enable
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    // Register port
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic                wr_stb,
    input  wire logic                rd_stb,
    output logic      [DATA_W-1:0]   rdata,
    // System state
    input  wire logic                wait_mode,
    input  wire logic                stop_mode,
    input  wire logic                break_active,
    input  wire logic                break_clear_allow,
    // Requests, channel gating and count value
    output logic                     wrap_irq,
    output logic      [NUM_CHAN-1:0] capture_inhibit,
    output logic      [COUNT_W-1:0]  count_value
);

    // ==================================================================
    // State
    logic                                   wrap_flag_reg;
    logic                                   wrap_flag_next;
    logic                                   clear_armed_reg;
    logic                                   clear_armed_next;
    logic                                   wrap_irq_enable_reg;
    logic                                   wrap_irq_enable_next;
    logic                                   count_halt_reg;
    logic                                   count_halt_next;
    logic [count_core_pkg::DIV_SEL_W-1:0]   div_sel_reg;
    logic [count_core_pkg::DIV_SEL_W-1:0]   div_sel_next;
    logic [COUNT_W-1:0]                     count_reg;
    logic [COUNT_W-1:0]                     count_next;
    logic [COUNT_W-1:0]                     limit_reg;
    logic [COUNT_W-1:0]                     limit_next;
    logic                                   limit_pend_reg;
    logic                                   limit_pend_next;
    logic [DATA_W-1:0]                      low_buf_reg;
    logic [DATA_W-1:0]                      low_buf_next;
    logic                                   low_held_reg;
    logic                                   low_held_next;
    logic [DATA_W-1:0]                      rdata_reg;
    logic [DATA_W-1:0]                      rdata_next;
    logic                                   irq_reg;
    logic                                   irq_next;
    logic [NUM_CHAN-1:0]                    inhibit_reg;
    logic [NUM_CHAN-1:0]                    inhibit_next;

    // Decoded strobes and control terms
    logic            acc_ok;
    logic            wr_ok;
    logic            rd_ok;
    logic            clr_pulse;
    logic            run;
    logic            tick;
    logic            wrap_event;
    logic            status_clear_ok;
    logic [DATA_W-1:0] status_byte;

    // Access decode for one register
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] target);
        hit = (a == target);
    endfunction

    // ==================================================================
    // Access gating and run condition
    always_comb begin
        acc_ok          = !wait_mode;
        wr_ok           = wr_stb && acc_ok;
        rd_ok           = rd_stb && acc_ok;
        status_clear_ok = !break_active || break_clear_allow;
        clr_pulse       = wr_ok && hit(addr, count_core_pkg::ADDR_STATUS_CONTROL)
                          && wdata[count_core_pkg::BIT_CLEAR];
        // Runs in wait; idles in stop, break and halt
        run             = !count_halt_reg && !break_active && !stop_mode;
        wrap_event      = tick && (count_reg == limit_reg);
    end

    // Prescaler instance
    count_prescaler #(
        .PRESC_W (count_core_pkg::PRESC_W),
        .SEL_W   (count_core_pkg::DIV_SEL_W)
    ) u_prescaler (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ce      (ce),
        .run     (run),
        .clear   (clr_pulse),
        .sel     (div_sel_reg),
        .tick    (tick)
    );

    // ==================================================================
    // Counter and limit registers
    always_comb begin
        count_next      = count_reg;
        limit_next      = limit_reg;
        limit_pend_next = limit_pend_reg;
        if (clr_pulse) begin
            count_next = count_core_pkg::COUNT_RESET;
        end else if (wrap_event) begin
            count_next = count_core_pkg::COUNT_RESET;
        end else if (tick) begin
            count_next = COUNT_W'(count_reg + COUNT_W'(1));
        end
        if (wr_ok && hit(addr, count_core_pkg::ADDR_LIMIT_HIGH)) begin
            limit_next[COUNT_W-1:DATA_W] = wdata;
            limit_pend_next              = 1'b1;
        end
        if (wr_ok && hit(addr, count_core_pkg::ADDR_LIMIT_LOW)) begin
            limit_next[DATA_W-1:0] = wdata;
            limit_pend_next        = 1'b0;
        end
    end

    // ==================================================================
    // Status/control register and wrap flag
    always_comb begin
        wrap_flag_next       = wrap_flag_reg;
        clear_armed_next     = clear_armed_reg;
        wrap_irq_enable_next = wrap_irq_enable_reg;
        count_halt_next      = count_halt_reg;
        div_sel_next         = div_sel_reg;
        // Read while set arms the clear; blocked in protected break
        if (rd_ok && hit(addr, count_core_pkg::ADDR_STATUS_CONTROL)
            && wrap_flag_reg && status_clear_ok) begin
            clear_armed_next = 1'b1;
        end
        if (wr_ok && hit(addr, count_core_pkg::ADDR_STATUS_CONTROL)) begin
            wrap_irq_enable_next = wdata[count_core_pkg::BIT_WRAP_IE];
            count_halt_next      = wdata[count_core_pkg::BIT_HALT];
            div_sel_next         = wdata[count_core_pkg::DIV_SEL_LSB +:
                                         count_core_pkg::DIV_SEL_W];
            if (!wdata[count_core_pkg::BIT_WRAP_FLAG] && clear_armed_reg
                && status_clear_ok) begin
                wrap_flag_next   = 1'b0;
                clear_armed_next = 1'b0;
            end
        end
        // New wrap wins over a clear and cancels the armed step
        if (wrap_event && !limit_pend_reg) begin
            wrap_flag_next   = 1'b1;
            clear_armed_next = 1'b0;
        end
    end

    // ==================================================================
    // Counter byte pair read latch
    always_comb begin
        low_buf_next  = low_buf_reg;
        low_held_next = low_held_reg;
        if (rd_ok && hit(addr, count_core_pkg::ADDR_COUNT_HIGH) && !low_held_reg) begin
            low_buf_next  = count_reg[DATA_W-1:0];
            low_held_next = 1'b1;
        end
        if (rd_ok && hit(addr, count_core_pkg::ADDR_COUNT_LOW)) begin
            low_held_next = 1'b0;
        end
    end

    // ==================================================================
    // Read data, one cycle after the strobe
    always_comb begin
        status_byte = count_core_pkg::BYTE_ZERO;
        status_byte[count_core_pkg::BIT_WRAP_FLAG] = wrap_flag_reg;
        status_byte[count_core_pkg::BIT_WRAP_IE]   = wrap_irq_enable_reg;
        status_byte[count_core_pkg::BIT_HALT]      = count_halt_reg;
        status_byte[count_core_pkg::DIV_SEL_LSB +: count_core_pkg::DIV_SEL_W] = div_sel_reg;
        rdata_next = count_core_pkg::BYTE_ZERO;
        if (rd_ok) begin
            unique case (addr)
                count_core_pkg::ADDR_STATUS_CONTROL: begin
                    rdata_next = status_byte;
                end
                count_core_pkg::ADDR_COUNT_HIGH: begin
                    rdata_next = count_reg[COUNT_W-1:DATA_W];
                end
                count_core_pkg::ADDR_COUNT_LOW: begin
                    rdata_next = low_held_reg ? low_buf_reg : count_reg[DATA_W-1:0];
                end
                count_core_pkg::ADDR_LIMIT_HIGH: begin
                    rdata_next = limit_reg[COUNT_W-1:DATA_W];
                end
                count_core_pkg::ADDR_LIMIT_LOW: begin
                    rdata_next = limit_reg[DATA_W-1:0];
                end
                default: begin
                    rdata_next = count_core_pkg::BYTE_ZERO;
                end
            endcase
        end
    end

    // ==================================================================
    // Registered outputs
    always_comb begin
        irq_next     = wrap_flag_next && wrap_irq_enable_next;
        // One inhibit per channel pin; channel logic sits outside
        inhibit_next = {NUM_CHAN{count_halt_next || break_active}};
    end

    // ==================================================================
    // State registers; clock enable freezes everything

    // Counter and limit registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg      <= count_core_pkg::COUNT_RESET;
            limit_reg      <= count_core_pkg::LIMIT_RESET;
            limit_pend_reg <= 1'b0;
        end else if (ce) begin
            count_reg      <= count_next;
            limit_reg      <= limit_next;
            limit_pend_reg <= limit_pend_next;
        end
    end

    // Status/control bits and armed clear step
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrap_flag_reg       <= 1'b0;
            clear_armed_reg     <= 1'b0;
            wrap_irq_enable_reg <= 1'b0;
            count_halt_reg      <= 1'b1;
            div_sel_reg         <= count_core_pkg::DIV_SEL_RESET;
        end else if (ce) begin
            wrap_flag_reg       <= wrap_flag_next;
            clear_armed_reg     <= clear_armed_next;
            wrap_irq_enable_reg <= wrap_irq_enable_next;
            count_halt_reg      <= count_halt_next;
            div_sel_reg         <= div_sel_next;
        end
    end

    // Low byte latch
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            low_buf_reg  <= count_core_pkg::BYTE_ZERO;
            low_held_reg <= 1'b0;
        end else if (ce) begin
            low_buf_reg  <= low_buf_next;
            low_held_reg <= low_held_next;
        end
    end

    // Read data register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= count_core_pkg::BYTE_ZERO;
        end else if (ce) begin
            rdata_reg <= rdata_next;
        end
    end

    // Request and inhibit outputs; inhibits start high while halted
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_reg     <= 1'b0;
            inhibit_reg <= {NUM_CHAN{1'b1}};
        end else if (ce) begin
            irq_reg     <= irq_next;
            inhibit_reg <= inhibit_next;
        end
    end

    // Output wiring from flops
    assign rdata           = rdata_reg;
    assign wrap_irq        = irq_reg;
    assign capture_inhibit = inhibit_reg;
    assign count_value     = count_reg;

endmodule // prescaled_count_core

// ===== bench/prescaled_count_core_assertions.sv
// Checker for the prescaled count core, bound to its top module ports.
// Assumes the single ref_clk domain with active low asynchronous rstn.
module prescaled_count_core_assertions #(
    parameter int unsigned NUM_CHAN = 4,
    parameter int unsigned ADDR_W   = count_core_pkg::ADDR_W,
    parameter int unsigned DATA_W   = count_core_pkg::DATA_W,
    parameter int unsigned COUNT_W  = count_core_pkg::COUNT_W
) (
    // Clock and reset
    input wire logic                ref_clk,
    input wire logic                rstn,
    input wire logic                ce,
    // Register port
    input wire logic [ADDR_W-1:0]   addr,
    input wire logic [DATA_W-1:0]   wdata,
    input wire logic                wr_stb,
    input wire logic                rd_stb,
    input wire logic [DATA_W-1:0]   rdata,
    // System state
    input wire logic                wait_mode,
    input wire logic                stop_mode,
    input wire logic                break_active,
    input wire logic                break_clear_allow,
    // Outputs
    input wire logic                wrap_irq,
    input wire logic [NUM_CHAN-1:0] capture_inhibit,
    input wire logic [COUNT_W-1:0]  count_value
);
    // ==================================================================
    // Shadow of the control bits
    logic       ctl_wr;
    logic       halt_reg, halt_next, ie_reg, ie_next;
    logic [2:0] sel_reg, sel_next;

    // Accepted status/control write
    assign ctl_wr = ce && wr_stb && !wait_mode && addr == count_core_pkg::ADDR_STATUS_CONTROL;

    // Next control values
    always_comb begin
        halt_next = halt_reg;
        ie_next   = ie_reg;
        sel_next  = sel_reg;
        if (ctl_wr) begin
            halt_next = wdata[count_core_pkg::BIT_HALT];
            ie_next   = wdata[count_core_pkg::BIT_WRAP_IE];
            sel_next  = wdata[2:0];
        end
    end

    // Control shadow registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            halt_reg <= 1'b1;
            ie_reg   <= 1'b0;
            sel_reg  <= count_core_pkg::DIV_SEL_RESET;
        end else begin
            halt_reg <= halt_next;
            ie_reg   <= ie_next;
            sel_reg  <= sel_next;
        end
    end

    // ==================================================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_halt_clear_wr;
        ctl_wr && wdata[count_core_pkg::BIT_HALT] && wdata[count_core_pkg::BIT_CLEAR];
    endsequence
    sequence s_quiet;
        (!wr_stb && ce)[*3];
    endsequence

    a_halt_freezes: assert property (ce && halt_reg && !wr_stb |=> $stable(count_value))
        else $error("count moved while halted");
    a_stop_holds: assert property (ce && stop_mode && !wr_stb |=> $stable(count_value))
        else $error("count moved in stop");
    a_break_holds: assert property (ce && break_active && !wr_stb |=> $stable(count_value))
        else $error("count moved in break");
    a_inhibit_gate: assert property (ce && !ctl_wr && (halt_reg || break_active)
        |=> &capture_inhibit)
        else $error("capture not inhibited");
    a_irq_enable: assert property (wrap_irq |-> ie_reg)
        else $error("wrap request without enable");
    a_wait_reads: assert property (ce && rd_stb && wait_mode |=> rdata == 8'h00)
        else $error("register read in wait");
    a_rdata_idle: assert property (ce && !rd_stb |=> rdata == 8'h00)
        else $error("read data outside read slot");
    a_clear_zeroes: assert property (ctl_wr && wdata[count_core_pkg::BIT_CLEAR]
        |=> count_value == 16'h0000)
        else $error("clear did not zero count");
    a_halt_clear: assert property (s_halt_clear_wr ##1 s_quiet |-> count_value == 16'h0000)
        else $error("halt with clear left nonzero");
    a_sel_none: assert property (ce && sel_reg == 3'h7 && !wr_stb |=> $stable(count_value))
        else $error("count moved with divider 7");
    a_step_one: assert property ($changed(count_value) |->
        count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000)
        else $error("count step not one");
endmodule // prescaled_count_core_assertions

bind prescaled_count_core prescaled_count_core_assertions #(.NUM_CHAN(NUM_CHAN))
    prescaled_count_core_assertions_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .break_active(break_active), .break_clear_allow(break_clear_allow),
    .wrap_irq(wrap_irq), .capture_inhibit(capture_inhibit), .count_value(count_value));

// ===== bench/prescaled_count_core_tb.sv
// Self-checking bench for the prescaled count core.
// Assumes the strobe register port and a 200 MHz ref_clk.
module prescaled_count_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ==================================================================
    // Signals
    logic        ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00, rdata, got;
    logic        wr_stb = 1'b0, rd_stb = 1'b0, wrap_irq;
    logic        wait_mode = 1'b0, stop_mode = 1'b0, break_active = 1'b0;
    logic        break_clear_allow = 1'b0;
    logic [3:0]  capture_inhibit;
    logic [15:0] count_value, v, w;
    int          error_cnt = 0, check_count = 0, cyc = 0;
    logic [2:0]  row_addr [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    logic [7:0]  row_exp  [7] = '{8'h20, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};

    prescaled_count_core prescaled_count_core_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .break_active(break_active),
        .break_clear_allow(break_clear_allow), .wrap_irq(wrap_irq),
        .capture_inhibit(capture_inhibit), .count_value(count_value));

    // Clock and hang guard
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // ==================================================================
    // Compare and bus tasks
    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %b seen %b", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd_chk(logic [2:0] a, logic [7:0] e, string n);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 chk_byte(n, e, rdata);
    endtask
    // Count must move, or must stand, over ten cycles
    task automatic hold_chk(string n, logic moving);
        @(posedge ref_clk);
        #1 v = count_value;
        repeat (10) @(posedge ref_clk);
        #1 chk_bit(n, moving, count_value !== v);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        chk_bit("inhibit_reset", 1'b1, &capture_inhibit);
        for (int i = 0; i < 7; i++) begin
            rd_chk(row_addr[i], row_exp[i], "reset_value");
        end
        // Prescaler divide ratios, then divider 7
        for (int s = 0; s < 7; s++) begin
            wr(3'h0, 8'h30);
            wr(3'h0, 8'h10 | 8'(s));
            repeat (8 << s) @(posedge ref_clk);
            #1 chk_bit("prescale", 1'b1, count_value >= 6 && count_value <= 9);
        end
        // Divider 7 without clear, so the count stays nonzero
        wr(3'h0, 8'h07);
        hold_chk("div_none", 1'b0);
        // Wrap, flag, request and clear sequence
        wr(3'h0, 8'h30);
        #1 chk_byte("halt_clear_lo", 8'h00, count_value[7:0]);
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h05);
        wr(3'h0, 8'h50);
        repeat (12) @(posedge ref_clk);
        rd_chk(3'h0, 8'hC0, "wrap_set");
        chk_bit("irq_on", 1'b1, wrap_irq);
        chk_bit("wrap_bound", 1'b1, count_value <= 16'h0005);
        repeat (12) @(posedge ref_clk);
        wr(3'h0, 8'h60);
        rd_chk(3'h0, 8'hE0, "clear_cancelled");
        wr(3'h0, 8'hE0);
        rd_chk(3'h0, 8'hE0, "write_one");
        break_active <= 1'b1;
        wr(3'h0, 8'h60);
        rd_chk(3'h0, 8'hE0, "break_keeps");
        break_active <= 1'b0;
        wr(3'h0, 8'h60);
        rd_chk(3'h0, 8'h60, "after_break");
        chk_bit("irq_off", 1'b0, wrap_irq);
        // Flag masked while the limit high byte is pending
        wr(3'h3, 8'h00);
        wr(3'h0, 8'h40);
        repeat (20) @(posedge ref_clk);
        rd_chk(3'h0, 8'h40, "limit_pending");
        wr(3'h4, 8'h05);
        repeat (12) @(posedge ref_clk);
        wr(3'h0, 8'h20);
        #1 chk_bit("irq_masked", 1'b0, wrap_irq);
        // Clear allowed in break; flag stays cleared after it
        break_active      <= 1'b1;
        break_clear_allow <= 1'b1;
        rd_chk(3'h0, 8'hA0, "flag_no_ie");
        wr(3'h0, 8'h20);
        break_active      <= 1'b0;
        break_clear_allow <= 1'b0;
        rd_chk(3'h0, 8'h20, "flag_cleared");
        // Low byte latch on high byte read
        wr(3'h3, 8'hFF);
        wr(3'h4, 8'hFF);
        wr(3'h0, 8'h10);
        repeat (300) @(posedge ref_clk);
        wr(3'h0, 8'h20);
        repeat (2) @(posedge ref_clk);
        v = count_value;
        rd_chk(3'h1, v[15:8], "high_first");
        wr(3'h0, 8'h00);
        repeat (20) @(posedge ref_clk);
        wr(3'h0, 8'h20);
        repeat (2) @(posedge ref_clk);
        w = count_value;
        rd_chk(3'h1, w[15:8], "high_again");
        rd_chk(3'h2, v[7:0], "low_latched");
        rd_chk(3'h2, w[7:0], "low_released");
        // Wait, stop, break and clock enable
        wr(3'h0, 8'h00);
        wait_mode <= 1'b1;
        wr(3'h0, 8'h30);
        hold_chk("wait_runs", 1'b1);
        rd_chk(3'h0, 8'h00, "wait_read");
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        hold_chk("stop_idle", 1'b0);
        stop_mode <= 1'b0;
        hold_chk("stop_resume", 1'b1);
        break_active <= 1'b1;
        hold_chk("break_idle", 1'b0);
        chk_bit("break_inhibit", 1'b1, &capture_inhibit);
        rd_chk(3'h1, v[15:8], "break_high");
        rd_chk(3'h2, v[7:0], "break_low");
        break_active <= 1'b0;
        ce <= 1'b0;
        hold_chk("ce_low", 1'b0);
        ce <= 1'b1;
        wr(3'h0, 8'h20);
        hold_chk("halted", 1'b0);
        chk_bit("halt_inhibit", 1'b1, &capture_inhibit);
        wr(3'h0, 8'h30);
        rd_chk(3'h0, 8'h20, "clear_reads_zero");
        chk_bit("cleared", 1'b1, count_value === 16'h0000);
        give_verdict();
    end
endmodule // prescaled_count_core_tb
